// [rtl/psr_edge.sv]
`timescale 1ns/1ps
`default_nettype none

module psr_edge
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  always_comb
  begin
    nxt_meta = pin;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;

endmodule

`default_nettype wire

// [rtl/psr_pkg.sv]
`default_nettype none

package psr_pkg;

  typedef enum logic [2:0]
  {
    PSR_IDLE = 3'b000,
    PSR_ACK  = 3'b001,
    PSR_SPIN = 3'b010,
    PSR_CONV = 3'b011,
    PSR_READ = 3'b100
  } psr_state_t;

  typedef enum logic [2:0]
  {
    PSR_CMD_NONE = 3'b000,
    PSR_CMD_PRES = 3'b001,
    PSR_CMD_TEMP = 3'b010,
    PSR_CMD_CAL1 = 3'b011,
    PSR_CMD_CAL2 = 3'b100,
    PSR_CMD_CAL3 = 3'b101,
    PSR_CMD_CAL4 = 3'b110
  } psr_cmd_t;

  typedef struct packed
  {
    logic sclk;
    logic din;
    logic mclk;
  } psr_pins_t;

endpackage

`default_nettype wire

// [rtl/psr_readout.sv]
// How it works
// - Instruction bits on the input line are captured at serial clock rising edges.
// - The output line changes at serial clock rising edges, and falls once at conversion completion.
// - Output carries a conversion result or calibration data, per last instruction.
// - Seven commands: pressure, temperature, four calibration reads, reset.
// - No chip select; every transaction opens with an instruction sequence.
// - Setup field framed by three high start bits and three low stop bits.
// - Four-bit setup field selects pressure, temperature or calibration data.
// - Conversion start is acknowledged by the output rising low to high.
// - Seventeen serial clocks shift out the sixteen-bit result.
// - Readout may pause with clock held; position is kept.
// - Reset pattern is recognised in any state and returns to idle.
// - Reset sequence is twenty-one serial bits on the input line.
// - Sixty-four-bit calibration store read as four sixteen-bit words.
// - Pressure and temperature results are sixteen-bit unsigned words.
// - Calibration words pack six coefficients, two split across words.
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.svh"

module psr_readout
  import psr_pkg::*;
#(
  parameter logic [3:0]  CODE_PRES   = `PSR_CODE_PRES,
  parameter logic [3:0]  CODE_TEMP   = `PSR_CODE_TEMP,
  parameter logic [3:0]  CODE_CAL1   = `PSR_CODE_CAL1,
  parameter logic [3:0]  CODE_CAL2   = `PSR_CODE_CAL2,
  parameter logic [3:0]  CODE_CAL3   = `PSR_CODE_CAL3,
  parameter logic [3:0]  CODE_CAL4   = `PSR_CODE_CAL4,
  parameter logic [20:0] RST_PATTERN = `PSR_RST_PATTERN,
  parameter logic [63:0] CALIB_STORE = `PSR_CALIB_INIT,
  parameter logic [11:0] CONV_MCLKS  = `PSR_CONV_MCLKS
)
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        SCLK,
  input  wire logic        DIN,
  input  wire logic        MCLK,
  input  wire logic [15:0] ADC_SAMPLE,
  output logic             DOUT,
  output logic             CONV_BUSY,
  output logic             CONV_TEMP
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  psr_pins_t lvl;
  psr_pins_t rise;

  psr_edge u_sclk (.clk(REF_CLK), .rst_n(NRST), .pin(SCLK), .level(lvl.sclk), .rise(rise.sclk));
  psr_edge u_din  (.clk(REF_CLK), .rst_n(NRST), .pin(DIN),  .level(lvl.din),  .rise(rise.din));
  psr_edge u_mclk (.clk(REF_CLK), .rst_n(NRST), .pin(MCLK), .level(lvl.mclk), .rise(rise.mclk));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic psr_cmd_t decode(input logic [3:0] code);
    psr_cmd_t c;
    c = PSR_CMD_NONE;
    if (code == CODE_PRES)      c = PSR_CMD_PRES;
    else if (code == CODE_TEMP) c = PSR_CMD_TEMP;
    else if (code == CODE_CAL1) c = PSR_CMD_CAL1;
    else if (code == CODE_CAL2) c = PSR_CMD_CAL2;
    else if (code == CODE_CAL3) c = PSR_CMD_CAL3;
    else if (code == CODE_CAL4) c = PSR_CMD_CAL4;
    return c;
  endfunction

  // Word order follows the store from its top bits down
  function automatic logic [15:0] calib_word(input logic [1:0] idx);
    logic [15:0] w;
    case (idx)
      2'h0:    w = CALIB_STORE[63:48];
      2'h1:    w = CALIB_STORE[47:32];
      2'h2:    w = CALIB_STORE[31:16];
      default: w = CALIB_STORE[15:0];
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  psr_state_t  state_ff,  nxt_state;
  logic [20:0] hist_ff,   nxt_hist;
  logic [3:0]  fill_ff,   nxt_fill;
  logic [4:0]  cnt_ff,    nxt_cnt;
  logic [11:0] mcnt_ff,   nxt_mcnt;
  logic [15:0] shift_ff,  nxt_shift;
  logic        dout_ff,   nxt_dout;
  logic        busy_ff,   nxt_busy;
  logic        temp_ff,   nxt_temp;
  logic        rst_hit;
  logic        frame_ok;
  psr_cmd_t    cmd;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_hist  = hist_ff;
    nxt_fill  = fill_ff;
    nxt_cnt   = cnt_ff;
    nxt_mcnt  = mcnt_ff;
    nxt_shift = shift_ff;
    nxt_dout  = dout_ff;
    nxt_busy  = busy_ff;
    nxt_temp  = temp_ff;
    if (rise.sclk)
      nxt_hist = {hist_ff[19:0], lvl.din};
    rst_hit  = rise.sclk && (nxt_hist == RST_PATTERN);
    frame_ok = (nxt_hist[`PSR_START_MSB:`PSR_START_LSB] == `PSR_START_BITS)
            && (nxt_hist[`PSR_STOP_MSB:`PSR_STOP_LSB] == `PSR_STOP_BITS);
    cmd      = decode(nxt_hist[`PSR_SETUP_MSB:`PSR_SETUP_LSB]);
    if (rst_hit)
    begin
      // Reset wins over every state so a lost host can always recover
      nxt_state = PSR_IDLE;
      nxt_fill  = 4'h0;
      nxt_dout  = 1'b0;
      nxt_busy  = 1'b0;
    end
    else
    begin
      case (state_ff)
        PSR_IDLE:
          if (rise.sclk)
          begin
            // Only bits shifted since idle may form a frame
            if (fill_ff != `PSR_FRAME_FULL)
              nxt_fill = fill_ff + 4'h1;
            if ((nxt_fill == `PSR_FRAME_FULL) && frame_ok && (cmd != PSR_CMD_NONE))
            begin
              nxt_fill = 4'h0;
              nxt_cnt  = 5'h00;
              nxt_temp = (cmd == PSR_CMD_TEMP);
              case (cmd)
                PSR_CMD_PRES, PSR_CMD_TEMP: nxt_state = PSR_ACK;
                default:
                begin
                  nxt_state = PSR_READ;
                  nxt_shift = calib_word(2'(cmd - PSR_CMD_CAL1));
                end
              endcase
            end
          end
        PSR_ACK:
          if (rise.sclk)
          begin
            nxt_dout  = 1'b1;
            nxt_busy  = 1'b1;
            nxt_mcnt  = 12'h000;
            nxt_cnt   = 5'h00;
            nxt_state = PSR_SPIN;
          end
        PSR_SPIN, PSR_CONV:
        begin
          if (rise.mclk && (mcnt_ff != CONV_MCLKS))
            nxt_mcnt = mcnt_ff + 12'h001;
          if (state_ff == PSR_SPIN)
          begin
            if (rise.sclk)
            begin
              if (cnt_ff == `PSR_ACK_LAST)
                nxt_state = PSR_CONV;
              else
                nxt_cnt = cnt_ff + 5'h01;
            end
          end
          else if (mcnt_ff == CONV_MCLKS)
          begin
            // Completion edge; the only output change not tied to the clock
            nxt_dout  = 1'b0;
            nxt_busy  = 1'b0;
            nxt_shift = ADC_SAMPLE;
            nxt_cnt   = 5'h00;
            nxt_state = PSR_READ;
          end
        end
        PSR_READ:
          if (rise.sclk)
          begin
            if (cnt_ff == `PSR_READ_LAST)
            begin
              nxt_dout  = 1'b0;
              nxt_state = PSR_IDLE;
            end
            else
            begin
              nxt_dout  = shift_ff[`PSR_WORD_MSB];
              nxt_shift = {shift_ff[14:0], 1'b0};
              nxt_cnt   = cnt_ff + 5'h01;
            end
          end
        default:
          nxt_state = PSR_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_ff <= PSR_IDLE;
      hist_ff  <= 21'h000000;
      fill_ff  <= 4'h0;
      cnt_ff   <= 5'h00;
      mcnt_ff  <= 12'h000;
      shift_ff <= 16'h0000;
      dout_ff  <= 1'b0;
      busy_ff  <= 1'b0;
      temp_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      hist_ff  <= nxt_hist;
      fill_ff  <= nxt_fill;
      cnt_ff   <= nxt_cnt;
      mcnt_ff  <= nxt_mcnt;
      shift_ff <= nxt_shift;
      dout_ff  <= nxt_dout;
      busy_ff  <= nxt_busy;
      temp_ff  <= nxt_temp;
    end
  end

  assign DOUT      = dout_ff;
  assign CONV_BUSY = busy_ff;
  assign CONV_TEMP = temp_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence s_ack_edge;
    state_ff == PSR_ACK && rise.sclk && !rst_hit;
  endsequence

  sequence s_spin_done;
    state_ff == PSR_SPIN && rise.sclk && !rst_hit && cnt_ff == `PSR_ACK_LAST;
  endsequence

  din_capture_a: assert property (rise.sclk |=> hist_ff[0] == $past(lvl.din))
    else $error("input bit not captured at clock edge");

  dout_edge_a: assert property ((!rise.sclk && state_ff != PSR_CONV) |=> $stable(DOUT))
    else $error("output changed without serial clock edge");

  ack_rise_a: assert property (s_ack_edge |=> DOUT && $rose(DOUT) && state_ff == PSR_SPIN)
    else $error("conversion start not acknowledged");

  spin_conv_a: assert property (s_spin_done |=> state_ff == PSR_CONV && DOUT)
    else $error("conversion wait not entered after two clocks");

  conv_done_a: assert property ((state_ff == PSR_CONV && mcnt_ff == CONV_MCLKS && !rst_hit)
    |=> $fell(DOUT) && state_ff == PSR_READ && shift_ff == $past(ADC_SAMPLE))
    else $error("completion not signalled or sample not latched");

  reset_any_a: assert property (rst_hit |=> state_ff == PSR_IDLE && !DOUT)
    else $error("reset pattern not honoured");

  read_end_a: assert property ((state_ff == PSR_READ && rise.sclk && !rst_hit
    && cnt_ff == `PSR_READ_LAST) |=> state_ff == PSR_IDLE && !DOUT)
    else $error("readout did not end on seventeenth clock");

  read_hold_a: assert property ((state_ff == PSR_READ && !rise.sclk)
    |=> $stable(cnt_ff) && $stable(shift_ff))
    else $error("readout position lost during clock hold");

  calib_load_a: assert property ((state_ff == PSR_IDLE && rise.sclk && !rst_hit
    && nxt_fill == `PSR_FRAME_FULL && frame_ok && cmd == PSR_CMD_CAL2)
    |=> state_ff == PSR_READ && shift_ff == CALIB_STORE[47:32])
    else $error("wrong calibration word selected");

  frame_pres_a: assert property ((state_ff == PSR_IDLE && rise.sclk && !rst_hit
    && nxt_fill == `PSR_FRAME_FULL && frame_ok && cmd == PSR_CMD_PRES)
    |=> state_ff == PSR_ACK && !CONV_TEMP)
    else $error("pressure frame not accepted");

endmodule

`default_nettype wire

// [rtl/psr_regs.svh]
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define PSR_START_BITS   3'h7
`define PSR_STOP_BITS    3'h0
`define PSR_FRAME_FULL   4'hA
`define PSR_START_MSB    9
`define PSR_START_LSB    7
`define PSR_SETUP_MSB    6
`define PSR_SETUP_LSB    3
`define PSR_STOP_MSB     2
`define PSR_STOP_LSB     0

// ----------------------------------------
// Setup codes and reset pattern defaults
// ----------------------------------------
`define PSR_CODE_PRES    4'hA
`define PSR_CODE_TEMP    4'h9
`define PSR_CODE_CAL1    4'h5
`define PSR_CODE_CAL2    4'h6
`define PSR_CODE_CAL3    4'hC
`define PSR_CODE_CAL4    4'h3
`define PSR_RST_PATTERN  21'h155540

// ----------------------------------------
// Counts
// ----------------------------------------
`define PSR_ACK_LAST     5'h01
`define PSR_READ_LAST    5'h10
`define PSR_CONV_MCLKS   12'h040
`define PSR_CALIB_INIT   64'h1234_5678_9ABC_DEF0
`define PSR_WORD_MSB     15

`endif

// [tb/pressure_sensor_serial_readout_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.svh"

module pressure_sensor_serial_readout_tb_top;
  localparam logic [63:0] CAL   = 64'hC3A5_0F1E_7B29_D648;
  localparam logic [20:0] RST   = `PSR_RST_PATTERN;
  localparam int          LIMIT = 30000;

  logic        ref_clk;
  logic        nrst;
  logic        sclk;
  logic        din;
  logic        mclk;
  logic [15:0] adc_sample;
  logic        dout;
  logic        conv_busy;
  logic        conv_temp;
  int          err_count;
  int          n_compared;
  int          cycles;
  logic [3:0]  cal_codes [4];

  psr_readout #(.CALIB_STORE(CAL), .CONV_MCLKS(12'h004)) psr_readout_i
  (
    .REF_CLK    (ref_clk),
    .NRST       (nrst),
    .SCLK       (sclk),
    .DIN        (din),
    .MCLK       (mclk),
    .ADC_SAMPLE (adc_sample),
    .DOUT       (dout),
    .CONV_BUSY  (conv_busy),
    .CONV_TEMP  (conv_temp)
  );

  psr_host_model psr_host_model_i
  (
    .ref_clk (ref_clk),
    .dout    (dout),
    .sclk    (sclk),
    .din     (din),
    .mclk    (mclk)
  );

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles >= LIMIT)
    begin
      err_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Calibration words leave the store from its top bits down
  function automatic logic [15:0] exp_cal(input int k);
    return CAL[63 - 16 * k -: 16];
  endfunction

  task automatic read_cal(input int k, input int pause_at);
    logic [15:0] w;
    logic        tail;
    psr_host_model_i.frame(cal_codes[k]);
    psr_host_model_i.read_word(w, tail, pause_at);
    check("cal_word", w, exp_cal(k));
    check("cal_tail", {15'h0000, tail}, 16'h0000);
  endtask

  task automatic convert(input logic temp, input int pause_at, input int abort_at);
    logic [15:0] smp;
    logic [15:0] w;
    logic        q;
    logic        ok;
    smp = 16'($urandom);
    adc_sample = smp;
    psr_host_model_i.reset_seq(RST);
    psr_host_model_i.frame(temp ? `PSR_CODE_TEMP : `PSR_CODE_PRES);
    psr_host_model_i.clock_bit(1'b0, q);
    check("ack", {15'h0000, q}, 16'h0001);
    check("busy", {15'h0000, conv_busy}, 16'h0001);
    psr_host_model_i.clock_bit(1'b0, q);
    psr_host_model_i.clock_bit(1'b0, q);
    check("temp_flag", {15'h0000, conv_temp}, {15'h0000, temp});
    if (abort_at > 0)
    begin
      // Lost sync: the reset overruns completion and lands mid-readout,
      // the only way to catch the pattern outside idle
      psr_host_model_i.reset_seq(RST);
      check("dout_idle", {15'h0000, dout}, 16'h0000);
      check("busy_idle", {15'h0000, conv_busy}, 16'h0000);
      read_cal(abort_at % 4, 16);
    end
    else
    begin
      psr_host_model_i.wait_done(ok);
      check("done", {15'h0000, ok}, 16'h0001);
      check("busy_end", {15'h0000, conv_busy}, 16'h0000);
      psr_host_model_i.read_word(w, q, pause_at);
      check("result", w, smp);
      check("res_tail", {15'h0000, q}, 16'h0000);
    end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    adc_sample = 16'h0000;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    cal_codes = '{`PSR_CODE_CAL1, `PSR_CODE_CAL2, `PSR_CODE_CAL3, `PSR_CODE_CAL4};
    void'($urandom(85));
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    check("dout_rst", {15'h0000, dout}, 16'h0000);
    check("busy_rst", {15'h0000, conv_busy}, 16'h0000);
    for (int k = 0; k < 4; k++) read_cal(k, 16);
    convert(1'b0, 16, 0);
    convert(1'b1, 7, 0);
    // Unknown setup code must leave the output quiet
    psr_host_model_i.frame(4'h0);
    for (int i = 0; i < 3; i++)
    begin
      psr_host_model_i.send_bits(21'h000000, 1);
      check("bad_code", {15'h0000, dout}, 16'h0000);
    end
    psr_host_model_i.reset_seq(RST);
    read_cal(3, 0);
    convert(1'b0, 16, 5);
    for (int n = 0; n < 8; n++)
    begin
      if ($urandom_range(0, 1) == 1)
        convert(1'($urandom_range(0, 1)), $urandom_range(0, 16), 0);
      else
        read_cal($urandom_range(0, 3), $urandom_range(0, 16));
    end
    give_verdict();
  end
endmodule

`default_nettype wire

// [tb/psr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module psr_host_model
(
  input  wire logic ref_clk,
  input  wire logic dout,
  output logic      sclk,
  output logic      din,
  output logic      mclk
);
  localparam int HALF       = 5;
  localparam int DONE_LIMIT = 400;
  localparam int MCLK_HALF  = 13;

  initial
  begin
    sclk = 1'b0;
    din  = 1'b0;
    mclk = 1'b0;
  end

  // ----------------------------------------
  // Master clock
  // ----------------------------------------
  // Unrelated to the serial clock, but it moves only on falling system
  // clock edges so the synchroniser never races a sampling edge
  always
  begin
    repeat (MCLK_HALF) @(negedge ref_clk);
    mclk = ~mclk;
  end

  // ----------------------------------------
  // Serial bit and word tasks
  // ----------------------------------------
  task automatic clock_bit(input logic b, output logic q);
    din = b;
    repeat (HALF) @(negedge ref_clk);
    sclk = 1'b1;
    repeat (HALF) @(negedge ref_clk);
    sclk = 1'b0;
    q = dout;
  endtask

  task automatic send_bits(input logic [20:0] v, input int n);
    logic q;
    for (int i = n - 1; i >= 0; i--) clock_bit(v[i], q);
  endtask

  task automatic frame(input logic [3:0] code);
    send_bits({11'h000, 3'h7, code, 3'h0}, 10);
  endtask

  // Output is not looked at while the pattern shifts
  task automatic reset_seq(input logic [20:0] pat);
    send_bits(pat, 21);
  endtask

  // Clock stays low while waiting; a bound stops a hang
  task automatic wait_done(output logic ok);
    int n;
    n = 0;
    while (dout === 1'b1 && n < DONE_LIMIT)
    begin
      @(negedge ref_clk);
      n++;
    end
    ok = (dout === 1'b0);
  endtask

  task automatic read_word(output logic [15:0] w, output logic tail, input int pause_at);
    logic q;
    for (int i = 15; i >= 0; i--)
    begin
      if (i == pause_at) repeat (40) @(negedge ref_clk);
      clock_bit(1'b0, q);
      w[i] = q;
    end
    clock_bit(1'b0, tail);
  endtask
endmodule

`default_nettype wire
